// ===== src/tap_params.svh
// Register offsets, bit positions and reset values of the tap flag logic
`ifndef TAP_PARAMS_SVH
`define TAP_PARAMS_SVH

`define TAP_CFG_ADDR      8'h21
`define TAP_SRC_ADDR      8'h22
`define TAP_RST_VAL       8'h00
`define TAP_ACCEL_W       8
`define TAP_THR_W         7

// Configuration bits
`define TAP_CFG_ABORT     7
`define TAP_CFG_LATCH     6
`define TAP_CFG_Z_DBL     5
`define TAP_CFG_Z_SGL     4
`define TAP_CFG_Y_DBL     3
`define TAP_CFG_Y_SGL     2
`define TAP_CFG_X_DBL     1
`define TAP_CFG_X_SGL     0

// Source bits
`define TAP_SRC_ACTIVE    7
`define TAP_SRC_DBL       3

`endif

// ===== src/tap_pkg.sv
// Types and shared functions of the tap flag logic
package tap_pkg;

   // Gray codes along idle, first pulse, latency, wait, second pulse
   typedef enum logic [2:0] {
      TAP_IDLE   = 3'h0,
      TAP_PULSE1 = 3'h1,
      TAP_LAT    = 3'h3,
      TAP_WAIT   = 3'h2,
      TAP_PULSE2 = 3'h6
   } tap_state_e;

   typedef logic [7:0] tap_byte_t;

   // Magnitude of a signed sample compared against an unsigned threshold
   function automatic logic tap_over(input logic [7:0] accel, input logic [6:0] thr);
      logic [7:0] mag;
      mag = accel[7] ? 8'(-accel) : accel;
      return mag > {1'b0, thr};
   endfunction

endpackage

// ===== src/tap_axis_seq.sv
// Per-axis single and double tap sequencer
`timescale 1ns/1ps
`include "tap_params.svh"

module tap_axis_seq
   import tap_pkg::*;
(
   input  wire logic         mclk,
   input  wire logic         sys_rst,
   input  wire logic         sample_tick,
   input  wire logic [7:0]   accel,
   input  wire logic [6:0]   threshold,
   input  wire logic         abort_en,
   input  wire logic         time_limit_ok,
   input  wire logic         latency_busy,
   input  wire logic         window_open,
   output logic              single_ev,
   output logic              double_ev,
   output logic              sign
);

   tap_state_e state_q, state_d;
   logic       in_pulse_q;
   logic       sign_q;
   logic       single_q;
   logic       double_q;

   wire over     = tap_over(accel, threshold);
   wire pulse_ok = !over && time_limit_ok;
   // A pulse that started and also ended inside the latency window
   wire lat_pulse_done = in_pulse_q && !over && latency_busy;

   always_comb begin
      state_d = state_q;
      case (state_q)
         TAP_IDLE: begin
            if (over)
               state_d = TAP_PULSE1;
         end
         TAP_PULSE1: begin
            if (pulse_ok)
               state_d = TAP_LAT;
            else if (!over)
               state_d = TAP_IDLE;
         end
         TAP_LAT: begin
            if (abort_en && lat_pulse_done)
               state_d = TAP_IDLE;
            else if (!latency_busy)
               state_d = TAP_WAIT;
         end
         TAP_WAIT: begin
            if (over)
               state_d = TAP_PULSE2;
            else if (!window_open)
               state_d = TAP_IDLE;
         end
         TAP_PULSE2: begin
            if (!over)
               state_d = TAP_IDLE;
         end
         default: state_d = TAP_IDLE;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state_q    <= TAP_IDLE;
         in_pulse_q <= 1'b0;
         sign_q     <= 1'b0;
         single_q   <= 1'b0;
         double_q   <= 1'b0;
      end else begin
         single_q <= 1'b0;
         double_q <= 1'b0;
         if (sample_tick) begin
            state_q    <= state_d;
            in_pulse_q <= (state_q == TAP_LAT) && over;
            if (state_q == TAP_IDLE && over)
               sign_q <= accel[7];
            if (state_q == TAP_WAIT && over)
               sign_q <= accel[7];
            single_q <= (state_q == TAP_PULSE1) && pulse_ok;
            double_q <= (state_q == TAP_PULSE2) && pulse_ok;
         end
      end
   end

   assign single_ev = single_q;
   assign double_ev = double_q;
   assign sign      = sign_q;

endmodule

// ===== src/tap_flag_logic.sv
// Tap configuration and source flag registers with per-axis sequencers
//
// Function
// - Configuration and source registers reset to zero
// - Abort clear: latency pulses do not stop detection
// - Abort set: pulse inside latency cancels double
// - Latch bit selects holding of event flags
// - Per-axis double tap enables bits 5,3,1
// - Per-axis single tap enables bits 4,2,0
// - Event reported only if axis and type enabled
// - Bit 7 set when any tap event occurred
// - Bits 6,5,4 flag Z, Y, X events
// - Bit 3 marks single or double tap
// - Bits 2,1,0 give Z, Y, X sign
// - Latched active event freezes other status bits
// - Reading source clears it and drops interrupt unless an enabled event arrives in that cycle
// - Pulses ignored during latency after first tap while abort bit clear
// - Seven-bit threshold per axis starts detection
`timescale 1ns/1ps
`include "tap_params.svh"

module tap_flag_logic
   import tap_pkg::*;
(
   input  wire logic         mclk,
   input  wire logic         sys_rst,
   input  wire logic [7:0]   reg_addr,
   input  wire logic         reg_wr,
   input  wire logic [7:0]   reg_wdata,
   input  wire logic         reg_rd,
   output logic [7:0]        reg_rdata,
   input  wire logic         sample_tick,
   input  wire logic [7:0]   accel_x,
   input  wire logic [7:0]   accel_y,
   input  wire logic [7:0]   accel_z,
   input  wire logic [6:0]   x_tap_threshold,
   input  wire logic [6:0]   y_tap_threshold,
   input  wire logic [6:0]   z_tap_threshold,
   input  wire logic         time_limit_ok,
   input  wire logic         latency_busy,
   input  wire logic         window_open,
   output logic              latency_start,
   output logic              tap_irq
);

   ////////////////////////////////////////////////////////////////////////////
   // Registers and decode

   tap_byte_t   tap_config_q;
   tap_byte_t   tap_source_q, tap_source_d;
   tap_byte_t   rdata_q;
   logic        irq_q;
   logic        lat_start_q;

   wire         cfg_sel  = (reg_addr == `TAP_CFG_ADDR);
   wire         src_sel  = (reg_addr == `TAP_SRC_ADDR);
   wire         cfg_wr   = reg_wr && cfg_sel;
   wire         src_rd   = reg_rd && src_sel;

   wire         double_tap_abort  = tap_config_q[`TAP_CFG_ABORT];
   wire         flag_latch_enable = tap_config_q[`TAP_CFG_LATCH];
   wire [2:0]   dbl_en = {tap_config_q[`TAP_CFG_Z_DBL], tap_config_q[`TAP_CFG_Y_DBL],
                          tap_config_q[`TAP_CFG_X_DBL]};
   wire [2:0]   sgl_en = {tap_config_q[`TAP_CFG_Z_SGL], tap_config_q[`TAP_CFG_Y_SGL],
                          tap_config_q[`TAP_CFG_X_SGL]};

   ////////////////////////////////////////////////////////////////////////////
   // Axis sequencers, index 2 is Z, 1 is Y, 0 is X

   logic [2:0]  sgl_ev;
   logic [2:0]  dbl_ev;
   logic [2:0]  axis_sign;
   wire  [7:0]  accel_v [3] = '{accel_z, accel_y, accel_x};
   wire  [6:0]  thr_v   [3] = '{z_tap_threshold, y_tap_threshold, x_tap_threshold};

   for (genvar i = 0; i < 3; i++) begin : g_axis
      tap_axis_seq u_seq (
         .mclk          (mclk),
         .sys_rst       (sys_rst),
         .sample_tick   (sample_tick),
         .accel         (accel_v[2 - i]),
         .threshold     (thr_v[2 - i]),
         .abort_en      (double_tap_abort),
         .time_limit_ok (time_limit_ok),
         .latency_busy  (latency_busy),
         .window_open   (window_open),
         .single_ev     (sgl_ev[i]),
         .double_ev     (dbl_ev[i]),
         .sign          (axis_sign[i])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // Event qualification

   wire [2:0]   sgl_hit  = sgl_ev & sgl_en;
   wire [2:0]   dbl_hit  = dbl_ev & dbl_en;
   wire [2:0]   axis_hit = sgl_hit | dbl_hit;
   wire         any_hit  = |axis_hit;
   wire         any_dbl  = |dbl_hit;
   wire         any_raw  = |(sgl_ev | dbl_ev);

   // source layout: active, axes, double, signs
   wire [7:0]   new_src  = {1'b1, axis_hit, any_dbl, axis_sign & axis_hit};
   wire         active   = tap_source_q[`TAP_SRC_ACTIVE];

   always_comb begin
      tap_source_d = tap_source_q;
      if (src_rd)
         tap_source_d = `TAP_RST_VAL;
      if (flag_latch_enable) begin
         // latched, frozen while active until read
         if (any_hit && (!active || src_rd))
            tap_source_d = new_src;
      end else if (any_hit) begin
         // unlatched tracks outcome; events trail the tick by one cycle
         tap_source_d = new_src;
      end else if (sample_tick) begin
         tap_source_d = `TAP_RST_VAL;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         tap_config_q <= `TAP_RST_VAL;
         tap_source_q <= `TAP_RST_VAL;
         rdata_q      <= `TAP_RST_VAL;
         irq_q        <= 1'b0;
         lat_start_q  <= 1'b0;
      end else begin
         if (cfg_wr)
            tap_config_q <= reg_wdata;
         tap_source_q <= tap_source_d;
         irq_q        <= tap_source_d[`TAP_SRC_ACTIVE];
         lat_start_q  <= any_raw;
         if (reg_rd)
            rdata_q <= cfg_sel ? tap_config_q :
                       src_sel ? tap_source_q : `TAP_RST_VAL;
      end
   end

   assign reg_rdata     = rdata_q;
   assign tap_irq       = irq_q;
   assign latency_start = lat_start_q;

endmodule

// ===== tb/tap_flag_logic_properties.sv
// Port assertions of the tap flag logic
`timescale 1ns/1ps
module tap_flag_logic_properties (
   input wire logic       mclk,
   input wire logic       sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic       reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       latency_start,
   input wire logic       tap_irq
);
   logic [7:0] cfg_q;
   wire        rd_src = reg_rd && reg_addr == 8'h22;
   // Shadow of the configuration register
   always_ff @(posedge mclk) begin
      if (sys_rst) cfg_q <= 8'h00;
      else if (reg_wr && reg_addr == 8'h21) cfg_q <= reg_wdata;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////
   AST_RST: assert property ($fell(sys_rst) |-> !tap_irq && reg_rdata == 8'h00)
      else $error("not clear after reset");
   AST_CFG: assert property (reg_rd && reg_addr == 8'h21 |=> reg_rdata == $past(cfg_q))
      else $error("config readback wrong");
   AST_EA: assert property (rd_src |=> reg_rdata[7] == $past(tap_irq))
      else $error("active bit differs from irq");
   AST_AXIS: assert property (rd_src |=> reg_rdata[7] == |reg_rdata[6:4])
      else $error("axis bits without active");
   AST_CLR: assert property (rd_src |=> !tap_irq || latency_start)
      else $error("read did not clear irq");
   AST_HOLD: assert property (cfg_q[6] && tap_irq && !rd_src |=> tap_irq)
      else $error("latched event lost");
   AST_CAUSE: assert property ($rose(tap_irq) |-> latency_start)
      else $error("irq without event");
   AST_OFF: assert property (cfg_q[5:0] == 6'h00 && !tap_irq |=> !tap_irq)
      else $error("irq with all events disabled");
endmodule
bind tap_flag_logic tap_flag_logic_properties u_props (.mclk, .sys_rst, .reg_addr, .reg_wr,
   .reg_wdata, .reg_rd, .reg_rdata, .latency_start, .tap_irq);

// ===== tb/tap_host.sv
// Host model driving the register strobe port
`timescale 1ns/1ps
module tap_host (
   input  wire logic mclk,
   output logic [7:0] reg_addr  = 8'h00,
   output logic       reg_wr    = 1'b0,
   output logic [7:0] reg_wdata = 8'h00,
   output logic       reg_rd    = 1'b0
);
   // One strobe cycle; released address and data show inverted values, strobes return low
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = w;
      reg_rd    = !w;
      @(negedge mclk);
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = ~a;
      reg_wdata = ~d;
   endtask
endmodule

// ===== tb/test_tap_flag_logic.sv
// Self-checking bench for the tap flag logic
`timescale 1ns/1ps
module test_tap_flag_logic;
   localparam logic [7:0] N = 8'h00, P = 8'h50, M = 8'hB0;
   logic       mclk = 1'b0, sys_rst = 1'b1, sample_tick = 1'b0, rd_d = 1'b0;
   logic       time_limit_ok = 1'b1, latency_busy = 1'b0, window_open = 1'b1;
   logic [7:0] ax = N, ay = N, az = N, cfg;
   logic [6:0] thr = 7'h10;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic       reg_wr, reg_rd, latency_start, tap_irq;
   logic [7:0] exp_q[$];
   int         error_cnt = 0, tests_run = 0, cyc = 0;
   always #20 mclk = ~mclk;
   tap_host u_host (.mclk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd);
   tap_flag_logic u_dut (.mclk, .sys_rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
      .reg_rdata, .sample_tick, .accel_x(ax), .accel_y(ay), .accel_z(az),
      .x_tap_threshold(thr), .y_tap_threshold(thr), .z_tap_threshold(thr),
      .time_limit_ok, .latency_busy, .window_open, .latency_start, .tap_irq);
   ////////////////////////////////////////
   task automatic end_of_test();
      $display("error_cnt %0d tests_run %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic cmp(input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch at %0t exp %h got %h", $time, e, g);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      u_host.acc(1'b0, a, N);
   endtask
   task automatic tk(input logic [7:0] x, input logic [7:0] y, input logic [7:0] z);
      @(negedge mclk);
      ax = x;
      ay = y;
      az = z;
      sample_tick = 1'b1;
      @(negedge mclk);
      sample_tick = 1'b0;
      repeat (3) @(negedge mclk);
   endtask
   task automatic rst();
      @(negedge mclk);
      sys_rst = 1'b1;
      repeat (2) @(negedge mclk);
      sys_rst = 1'b0;
   endtask
   ////////////////////////////////////////
   always @(posedge mclk) begin
      rd_d <= reg_rd;
      cyc <= cyc + 1;
      if (cyc == 1000) begin
         error_cnt++;
         end_of_test();
      end
   end
   // Read data is settled by the falling edge after the taking edge
   always @(negedge mclk) if (rd_d) cmp(exp_q.pop_front(), reg_rdata);
   initial begin
      void'($urandom(76));
      thr = 7'($urandom % 16);
      cfg = 8'($urandom);
      repeat (2) @(negedge mclk);
      sys_rst = 1'b0;
      rd(8'h21, N);
      rd(8'h22, N);
      rd(8'h30, N);
      u_host.acc(1'b1, 8'h21, cfg);
      u_host.acc(1'b1, 8'h22, 8'hFF);
      rd(8'h21, cfg);
      rd(8'h22, N);
      rst();
      u_host.acc(1'b1, 8'h21, 8'h45);
      tk(M, N, N);
      tk(N, N, N);
      tk(N, P, N);
      tk(N, N, N);
      rd(8'h22, 8'h91);
      rd(8'h22, N);
      rst();
      u_host.acc(1'b1, 8'h21, 8'h42);
      tk(P, N, N);
      tk(N, N, N);
      rd(8'h22, N);
      for (int i = 0; i < 2; i++) begin
         rst();
         u_host.acc(1'b1, 8'h21, {i[0], 7'h60});
         tk(N, N, P);
         tk(N, N, N);
         latency_busy = 1'b1;
         tk(N, N, P);
         tk(N, N, N);
         latency_busy = 1'b0;
         tk(N, N, N);
         tk(N, N, P);
         tk(N, N, N);
         rd(8'h22, i ? N : 8'hC8);
      end
      rst();
      u_host.acc(1'b1, 8'h21, 8'h01);
      tk(P, N, N);
      tk(N, N, N);
      rd(8'h22, 8'h90);
      tk(N, N, N);
      rd(8'h22, N);
      repeat (2) @(negedge mclk);
      end_of_test();
   end
endmodule
